// file: logic/rwd_pkg.sv
// rwd_pkg: register map, field positions, reset values and timing counts of the
// reset and watchdog controller. Assumes a 10 MHz system clock.
package rwd_pkg;
	// register byte offsets on the wishbone slave
	localparam logic [3:0] ADDR_PCR = 4'h0;
	localparam logic [3:0] ADDR_WCR = 4'h4;
	localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'hC;
	localparam int ADR_W = 4;

	// power_control_reg fields
	localparam int PCR_LOW_VOLTAGE_FLAG_BIT = 5;
	localparam int PCR_POF_BIT = 4;
	localparam logic [7:0] PCR_RST = 8'h10;
	localparam logic [7:0] PCR_PLAIN_MASK = 8'hCF;

	// watchdog_control_reg fields
	localparam int WCR_FLAG_BIT = 7;
	localparam int WCR_RUN_BIT = 5;
	localparam int WCR_KICK_BIT = 4;
	localparam int WCR_IDLE_BIT = 3;
	localparam int WCR_PS_LSB = 0;
	localparam int PS_W = 3;
	localparam logic [7:0] WCR_RST = 8'h00;

	// interrupt status and mask layout
	localparam int IRQ_WDT_BIT = 0;
	localparam int IRQ_LVD_BIT = 1;
	localparam int IRQ_PIN_BIT = 2;
	localparam int IRQ_POR_BIT = 3;
	localparam int IRQ_W = 4;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

	// timing
	localparam int CLK_HZ = 10_000_000;
	localparam int MACHINE_CLKS = 12;
	localparam int PRESCALE_W = 8;
	localparam int WDT_CNT_W = 15;
	localparam int PIN_MIN_CLKS = 24;
	localparam int PIN_EXTRA_NS = 10_000;
	localparam int PIN_FILTER_CLKS = PIN_MIN_CLKS
		+ (PIN_EXTRA_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int POR_DELAY_CLKS = 32768;
	localparam int RESET_HOLD_CLKS = PIN_MIN_CLKS;
endpackage

// file: logic/rwd_wdt_if.sv
// rwd_wdt_if: control and event signals between the controller and its watchdog.
// Assumes both ends share clk_i and the clock enable.
`timescale 1ns/1ns
interface rwd_wdt_if;
	logic count_en;
	logic kick;
	logic clear;
	logic [rwd_pkg::PS_W-1:0] prescale;
	logic overflow;

	modport ctrl (output count_en, output kick, output clear, output prescale, input overflow);
	modport wdt (input count_en, input kick, input clear, input prescale, output overflow);
endinterface

// file: logic/rwd_pin_filter.sv
// rwd_pin_filter: two-stage synchroniser and stability filter for an asynchronous pin.
// Assumes the pin is held stable for FILTER_CLKS cycles before a change counts.
`timescale 1ns/1ns
module rwd_pin_filter #(
	parameter int FILTER_CLKS = rwd_pkg::PIN_FILTER_CLKS
)(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// pin and filtered level
	input wire logic pin_i,
	output logic level_o
);
	localparam int CW = $clog2(FILTER_CLKS + 1);
	localparam logic [CW-1:0] LAST = CW'(FILTER_CLKS - 1);

	logic meta;
	logic sync;
	logic [CW-1:0] stable_cnt;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			meta <= 1'b0;
			sync <= 1'b0;
		end
		else if (ce_i)
		begin
			meta <= pin_i;
			sync <= meta;
		end
	end

	// short glitches restart the count and never reach the level
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			stable_cnt <= '0;
			level_o <= 1'b0;
		end
		else if (ce_i)
		begin
			if (sync == level_o)
				stable_cnt <= '0;
			else if (stable_cnt == LAST)
			begin
				stable_cnt <= '0;
				level_o <= sync;
			end
			else
				stable_cnt <= stable_cnt + 1'b1;
		end
	end

	property p_pin_filter;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && sync == level_o) |=> (stable_cnt == '0);
	endproperty
	a_pin_filter: assert property (p_pin_filter)
		else $error("pin filter count not restarted");
endmodule

// file: logic/rwd_watchdog.sv
// rwd_watchdog: machine-cycle divider, selectable prescaler and 15-bit counter.
// Assumes the controller gates counting and drives the kick as a one-cycle pulse.
`timescale 1ns/1ns
module rwd_watchdog #(
	parameter int MC_CLKS = rwd_pkg::MACHINE_CLKS,
	parameter int PRE_W = rwd_pkg::PRESCALE_W,
	parameter int CNT_W = rwd_pkg::WDT_CNT_W
)(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// controller side
	rwd_wdt_if.wdt wif
);
	localparam int MW = $clog2(MC_CLKS);
	localparam logic [MW-1:0] MC_LAST = MW'(MC_CLKS - 1);

	logic [MW-1:0] mc_cnt;
	logic [PRE_W-1:0] pre_cnt;
	logic [CNT_W-1:0] wdt_cnt;
	logic mc_tick;
	logic pre_tick;

	// division of 2 to the power of field plus one
	function automatic logic [PRE_W-1:0] pre_mask(input logic [rwd_pkg::PS_W-1:0] ps);
		pre_mask = PRE_W'((9'h002 << ps) - 9'h001);
	endfunction

	assign mc_tick = (mc_cnt == MC_LAST);
	assign pre_tick = mc_tick && ((pre_cnt & pre_mask(wif.prescale)) == pre_mask(wif.prescale));

	always_ff @(posedge clk_i)
	begin
		if (rst_i || (ce_i && (wif.kick || wif.clear)))
		begin
			mc_cnt <= '0;
			pre_cnt <= '0;
			wdt_cnt <= '0;
		end
		else if (ce_i && wif.count_en)
		begin
			mc_cnt <= mc_tick ? '0 : mc_cnt + 1'b1;
			if (mc_tick)
				pre_cnt <= pre_tick ? '0 : pre_cnt + 1'b1;
			if (pre_tick)
				wdt_cnt <= wdt_cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wif.overflow <= 1'b0;
		else if (ce_i)
			wif.overflow <= wif.count_en && !wif.kick && !wif.clear && pre_tick
				&& (&wdt_cnt);
	end

	property p_wdt_kick;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && wif.kick) |=> (wdt_cnt == '0 && pre_cnt == '0 && mc_cnt == '0);
	endproperty
	a_wdt_kick: assert property (p_wdt_kick)
		else $error("kick did not restart the watchdog");

	property p_wdt_stop;
		@(posedge clk_i) disable iff (rst_i)
		(!wif.count_en && !wif.kick && !wif.clear) |=> $stable(wdt_cnt) && $stable(pre_cnt);
	endproperty
	a_wdt_stop: assert property (p_wdt_stop)
		else $error("watchdog counted while stopped");

	property p_wdt_mc;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && wif.count_en && !wif.kick && !wif.clear && mc_cnt != MC_LAST)
			|=> $stable(pre_cnt);
	endproperty
	a_wdt_mc: assert property (p_wdt_mc)
		else $error("prescaler advanced off a machine cycle");

	property p_wdt_ovf;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && wif.count_en && !wif.kick && !wif.clear && pre_tick && (&wdt_cnt))
			|=> wif.overflow ##1 !wif.overflow || !ce_i;
	endproperty
	a_wdt_ovf: assert property (p_wdt_ovf)
		else $error("counter wrap without overflow pulse");
endmodule

// file: logic/rwd_reset_ctrl.sv
// rwd_reset_ctrl: reset merger, power flags and watchdog control behind a wishbone slave.
// Assumes pin, supply-detect and low-voltage inputs are asynchronous; the soft reset
// request and the idle indication come from logic on clk_i.
//
// Added by the designer: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module rwd_reset_ctrl #(
	parameter int POR_DELAY_CLKS = rwd_pkg::POR_DELAY_CLKS,
	parameter int WDT_MC_CLKS = rwd_pkg::MACHINE_CLKS,
	parameter int WDT_CNT_W = rwd_pkg::WDT_CNT_W
)(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [rwd_pkg::ADR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// reset sources and conditions
	input wire logic reset_pin_i,
	input wire logic supply_low_i,
	input wire logic low_voltage_i,
	input wire logic soft_reset_req_i,
	input wire logic cpu_idle_i,
	// results
	output logic chip_reset_o,
	output logic irq_o
);
	localparam int PW = $clog2(POR_DELAY_CLKS + 1);
	localparam logic [PW-1:0] POR_LAST = PW'(POR_DELAY_CLKS - 1);
	localparam int HW = $clog2(rwd_pkg::RESET_HOLD_CLKS + 1);
	localparam logic [HW-1:0] HOLD_LOAD = HW'(rwd_pkg::RESET_HOLD_CLKS);

	rwd_wdt_if wif ();

	logic pin_level;
	logic por_meta;
	logic por_sync;
	logic lv_meta;
	logic lv_sync;
	logic por_seen;
	logic [PW-1:0] por_cnt;
	logic por_busy;
	logic [HW-1:0] hold_cnt;
	logic pin_level_d;
	logic [7:0] pcr_plain;
	logic power_on_flag;
	logic low_voltage_flag;
	logic watchdog_reset_flag;
	logic watchdog_run;
	logic watchdog_in_sleep;
	logic [rwd_pkg::PS_W-1:0] watchdog_prescale;
	logic [rwd_pkg::IRQ_W-1:0] irq_stat;
	logic [rwd_pkg::IRQ_W-1:0] irq_mask;
	logic [rwd_pkg::IRQ_W-1:0] irq_event;
	logic bus_req;
	logic wr_lane;
	logic pcr_wr;
	logic wcr_wr;
	logic stat_wr;
	logic mask_wr;
	logic [7:0] next_dat;
	logic next_chip_reset;

	// reset pin filter
	rwd_pin_filter u_pin (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.pin_i(reset_pin_i),
		.level_o(pin_level)
	);

	rwd_watchdog #(.MC_CLKS(WDT_MC_CLKS), .CNT_W(WDT_CNT_W)) u_wdt (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.wif(wif)
	);

	// asynchronous supply conditions
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			por_meta <= 1'b0;
			por_sync <= 1'b0;
			lv_meta <= 1'b0;
			lv_sync <= 1'b0;
		end
		else if (ce_i)
		begin
			por_meta <= supply_low_i;
			por_sync <= por_meta;
			lv_meta <= low_voltage_i;
			lv_sync <= lv_meta;
		end
	end

	// bus decode; only the low byte lane carries register data
	assign bus_req = cyc_i && stb_i && !ack_o;
	assign wr_lane = bus_req && we_i && sel_i[0] && ce_i;
	assign pcr_wr = wr_lane && adr_i == rwd_pkg::ADDR_PCR;
	assign wcr_wr = wr_lane && adr_i == rwd_pkg::ADDR_WCR;
	assign stat_wr = wr_lane && adr_i == rwd_pkg::ADDR_IRQ_STAT;
	assign mask_wr = wr_lane && adr_i == rwd_pkg::ADDR_IRQ_MASK;

	// power-on delay; rst_i counts as a power-up, so the delay also runs after it
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			por_seen <= 1'b1;
			por_cnt <= '0;
		end
		else if (ce_i)
		begin
			if (por_sync)
			begin
				por_seen <= 1'b1;
				por_cnt <= '0;
			end
			else if (por_seen)
			begin
				if (por_cnt == POR_LAST)
					por_seen <= 1'b0;
				else
					por_cnt <= por_cnt + 1'b1;
			end
		end
	end
	assign por_busy = por_seen;

	// watchdog and software resets stretched so the whole chip sees them
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			hold_cnt <= '0;
		else if (ce_i)
		begin
			if (wif.overflow || soft_reset_req_i)
				hold_cnt <= HOLD_LOAD;
			else if (hold_cnt != '0)
				hold_cnt <= hold_cnt - 1'b1;
		end
	end

	// low pin level contributes nothing
	assign next_chip_reset = pin_level || por_sync || por_busy || wif.overflow
		|| soft_reset_req_i || hold_cnt != '0;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			chip_reset_o <= 1'b1;
		else if (ce_i)
			chip_reset_o <= next_chip_reset;
	end

	// power control flags: hardware set wins over a clearing write
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			power_on_flag <= rwd_pkg::PCR_RST[rwd_pkg::PCR_POF_BIT];
			low_voltage_flag <= rwd_pkg::PCR_RST[rwd_pkg::PCR_LOW_VOLTAGE_FLAG_BIT];
			pcr_plain <= rwd_pkg::PCR_RST & rwd_pkg::PCR_PLAIN_MASK;
		end
		else if (ce_i)
		begin
			if (por_sync)
				power_on_flag <= 1'b1;
			else if (pcr_wr && !dat_i[rwd_pkg::PCR_POF_BIT])
				power_on_flag <= 1'b0;
			if (lv_sync)
				low_voltage_flag <= 1'b1;
			else if (pcr_wr && !dat_i[rwd_pkg::PCR_LOW_VOLTAGE_FLAG_BIT])
				low_voltage_flag <= 1'b0;
			if (chip_reset_o)
				pcr_plain <= rwd_pkg::PCR_RST & rwd_pkg::PCR_PLAIN_MASK;
			else if (pcr_wr)
				pcr_plain <= dat_i[7:0] & rwd_pkg::PCR_PLAIN_MASK;
		end
	end

	// watchdog control; the flag survives the reset that it reports
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			watchdog_reset_flag <= rwd_pkg::WCR_RST[rwd_pkg::WCR_FLAG_BIT];
		else if (ce_i)
		begin
			if (wif.overflow)
				watchdog_reset_flag <= 1'b1;
			else if (wcr_wr && !dat_i[rwd_pkg::WCR_FLAG_BIT])
				watchdog_reset_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			watchdog_run <= rwd_pkg::WCR_RST[rwd_pkg::WCR_RUN_BIT];
			watchdog_in_sleep <= rwd_pkg::WCR_RST[rwd_pkg::WCR_IDLE_BIT];
			watchdog_prescale <= rwd_pkg::WCR_RST[rwd_pkg::WCR_PS_LSB +: rwd_pkg::PS_W];
		end
		else if (ce_i)
		begin
			if (chip_reset_o)
			begin
				watchdog_run <= rwd_pkg::WCR_RST[rwd_pkg::WCR_RUN_BIT];
				watchdog_in_sleep <= rwd_pkg::WCR_RST[rwd_pkg::WCR_IDLE_BIT];
				watchdog_prescale <= rwd_pkg::WCR_RST[rwd_pkg::WCR_PS_LSB +: rwd_pkg::PS_W];
			end
			else if (wcr_wr)
			begin
				watchdog_run <= dat_i[rwd_pkg::WCR_RUN_BIT];
				watchdog_in_sleep <= dat_i[rwd_pkg::WCR_IDLE_BIT];
				watchdog_prescale <= dat_i[rwd_pkg::WCR_PS_LSB +: rwd_pkg::PS_W];
			end
		end
	end

	// kick is a write strobe, never stored, so it always reads as zero
	assign wif.kick = wcr_wr && dat_i[rwd_pkg::WCR_KICK_BIT];
	assign wif.clear = chip_reset_o;
	assign wif.prescale = watchdog_prescale;
	assign wif.count_en = watchdog_run && !(cpu_idle_i && !watchdog_in_sleep);

	// interrupt status, write one to clear, new event wins
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			pin_level_d <= 1'b0;
		else if (ce_i)
			pin_level_d <= pin_level;
	end

	assign irq_event[rwd_pkg::IRQ_WDT_BIT] = wif.overflow;
	assign irq_event[rwd_pkg::IRQ_LVD_BIT] = lv_sync && !low_voltage_flag;
	assign irq_event[rwd_pkg::IRQ_PIN_BIT] = pin_level && !pin_level_d;
	assign irq_event[rwd_pkg::IRQ_POR_BIT] = por_sync && !power_on_flag;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			irq_stat <= '0;
			irq_mask <= rwd_pkg::IRQ_MASK_RST;
		end
		else if (ce_i)
		begin
			irq_stat <= (irq_stat & ~(stat_wr ? dat_i[rwd_pkg::IRQ_W-1:0] : '0)) | irq_event;
			if (mask_wr)
				irq_mask <= dat_i[rwd_pkg::IRQ_W-1:0];
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_o <= 1'b0;
		else if (ce_i)
			irq_o <= |(irq_stat & irq_mask);
	end

	// read mux; unmapped offsets answer with zero
	always_comb
	begin
		next_dat = 8'h00;
		case (adr_i)
			rwd_pkg::ADDR_PCR:
			begin
				next_dat = pcr_plain;
				next_dat[rwd_pkg::PCR_POF_BIT] = power_on_flag;
				next_dat[rwd_pkg::PCR_LOW_VOLTAGE_FLAG_BIT] = low_voltage_flag;
			end
			rwd_pkg::ADDR_WCR:
			begin
				next_dat[rwd_pkg::WCR_FLAG_BIT] = watchdog_reset_flag;
				next_dat[rwd_pkg::WCR_RUN_BIT] = watchdog_run;
				next_dat[rwd_pkg::WCR_IDLE_BIT] = watchdog_in_sleep;
				next_dat[rwd_pkg::WCR_PS_LSB +: rwd_pkg::PS_W] = watchdog_prescale;
			end
			rwd_pkg::ADDR_IRQ_STAT: next_dat = 8'(irq_stat);
			rwd_pkg::ADDR_IRQ_MASK: next_dat = 8'(irq_mask);
			default: next_dat = 8'h00;
		endcase
	end

	// one wait state: ack one edge after the request, dropped the next cycle
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end
		else if (ce_i)
		begin
			ack_o <= bus_req;
			if (bus_req && !we_i)
				dat_o <= {24'h00_0000, next_dat};
		end
	end

	sequence s_overflow;
		ce_i && wif.overflow;
	endsequence
	sequence s_reset_reported;
		chip_reset_o && watchdog_reset_flag;
	endsequence

	property p_wdt_reset;
		@(posedge clk_i) disable iff (rst_i)
		s_overflow |=> s_reset_reported;
	endproperty
	a_wdt_reset: assert property (p_wdt_reset)
		else $error("overflow did not reset and flag");

	property p_watchdog_reset_flag_hold;
		@(posedge clk_i) disable iff (rst_i)
		(watchdog_reset_flag && !wcr_wr) |=> watchdog_reset_flag;
	endproperty
	a_watchdog_reset_flag_hold: assert property (p_watchdog_reset_flag_hold)
		else $error("watchdog flag lost without a write");

	property p_pof_set;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && por_sync) |=> power_on_flag;
	endproperty
	a_pof_set: assert property (p_pof_set)
		else $error("power-on flag not set");

	property p_pof_hold;
		@(posedge clk_i) disable iff (rst_i)
		(power_on_flag && !pcr_wr) |=> power_on_flag;
	endproperty
	a_pof_hold: assert property (p_pof_hold)
		else $error("power-on flag cleared by other than software");

	property p_lvd_set;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && lv_sync) |=> low_voltage_flag ##1 (low_voltage_flag || $past(pcr_wr));
	endproperty
	a_lvd_set: assert property (p_lvd_set)
		else $error("low-voltage flag not held");

	property p_sources;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && (soft_reset_req_i || pin_level || por_busy)) |=> chip_reset_o;
	endproperty
	a_sources: assert property (p_sources)
		else $error("reset source did not reach chip reset");

	property p_por_release;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && por_sync) |=> por_busy && por_cnt == '0;
	endproperty
	a_por_release: assert property (p_por_release)
		else $error("power-on delay not restarted");

	property p_idle_gate;
		@(posedge clk_i) disable iff (rst_i)
		(cpu_idle_i && !watchdog_in_sleep) |-> !wif.count_en;
	endproperty
	a_idle_gate: assert property (p_idle_gate)
		else $error("watchdog counts in idle while suspended");

	property p_pin_reset;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && pin_level) |=> chip_reset_o;
	endproperty
	a_pin_reset: assert property (p_pin_reset)
		else $error("pin reset not applied");
endmodule

// file: testbench/rwd_pin_drv.sv
// rwd_pin_drv: behavioural driver of the external reset pin.
// Assumes the caller steps it from the bench clock; hold times are in clocks at 10 MHz.
`timescale 1ns/1ns
module rwd_pin_drv #(
	parameter int MIN_HOLD = 124
)(
	// clock
	input wire logic clk_i,
	// pin
	output logic pin_o
);
	// idle level is low so normal operation never resets
	initial pin_o = 1'b0;

	// a short request is stretched: the sampler drops anything briefer
	task automatic pulse(input int hold);
		int n;
		begin
			n = (hold < MIN_HOLD) ? MIN_HOLD : hold;
			@(posedge clk_i);
			pin_o <= 1'b1;
			repeat (n) @(posedge clk_i);
			pin_o <= 1'b0;
			repeat (n) @(posedge clk_i);
		end
	endtask
endmodule

// file: testbench/rwd_reset_ctrl_tb.sv
// rwd_reset_ctrl_tb: self-checking bench for the reset controller and a fast watchdog.
// Assumes the design package and interface are compiled first; 10 MHz clock.
`timescale 1ns/1ns
module rwd_reset_ctrl_tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [3:0] adr_i = 4'h0;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h00000000;
	logic [31:0] dat_o;
	logic ack_o;
	logic reset_pin_i;
	logic supply_low_i = 1'b0;
	logic low_voltage_i = 1'b0;
	logic soft_reset_req_i = 1'b0;
	logic cpu_idle_i = 1'b0;
	logic chip_reset_o;
	logic irq_o;
	logic [31:0] seed = 32'h369E;
	logic [31:0] q;
	int mismatches = 0;
	int total_checks = 0;
	int n;
	int m_pcr;
	int m_wcr;
	int m_sts;
	int m_msk;

	always #50 clk_i = ~clk_i;

	// two-clock machine cycle and 4-bit counter: watchdog timeout is 64 << ps clocks
	rwd_reset_ctrl #(.POR_DELAY_CLKS(64), .WDT_MC_CLKS(2), .WDT_CNT_W(4)) uut (.clk_i(clk_i),
		.rst_i(rst_i), .ce_i(ce_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
		.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .reset_pin_i(reset_pin_i),
		.supply_low_i(supply_low_i), .low_voltage_i(low_voltage_i),
		.soft_reset_req_i(soft_reset_req_i), .cpu_idle_i(cpu_idle_i),
		.chip_reset_o(chip_reset_o), .irq_o(irq_o));
	rwd_pin_drv drv (.clk_i(clk_i), .pin_o(reset_pin_i));

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task summarize;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task chk_reg(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task chk_bit(input logic got, input logic exp);
		total_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task chk_span(input int got, input int lo, input int hi);
		total_checks++;
		if (got < lo || got > hi)
		begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, lo);
		end
	endtask

	task wb(input logic w, input logic [3:0] a, input logic [7:0] v);
		int k;
		begin
			k = 0;
			cyc_i <= 1'b1;
			stb_i <= 1'b1;
			we_i <= w;
			sel_i <= 4'hF;
			adr_i <= a;
			dat_i <= {24'h000000, v};
			do
			begin
				@(posedge clk_i);
				k++;
			end while (ack_o !== 1'b1 && k < 16);
			q = dat_o;
			if (k >= 16)
				mismatches++;
			cyc_i <= 1'b0;
			stb_i <= 1'b0;
			we_i <= 1'b0;
			sel_i <= 4'h0;
			@(posedge clk_i);
		end
	endtask

	// model follows every write: flags clear on 0, status is write-one-to-clear
	task wr(input logic [3:0] a, input logic [7:0] v);
		wb(1'b1, a, v);
		case (a)
			rwd_pkg::ADDR_PCR: m_pcr = (v & 8'hCF) | (m_pcr & v & 8'h30);
			rwd_pkg::ADDR_WCR: m_wcr = (v & 8'h2F) | (m_wcr & v & 8'h80);
			rwd_pkg::ADDR_IRQ_STAT: m_sts = m_sts & ~v;
			rwd_pkg::ADDR_IRQ_MASK: m_msk = v & 8'h0F;
			default: ;
		endcase
	endtask

	task rd(input logic [3:0] a, input int exp);
		wb(1'b0, a, 8'h00);
		chk_reg(q, exp[31:0]);
	endtask

	task rd_all;
		rd(rwd_pkg::ADDR_PCR, m_pcr);
		rd(rwd_pkg::ADDR_WCR, m_wcr);
		rd(rwd_pkg::ADDR_IRQ_STAT, m_sts);
		rd(rwd_pkg::ADDR_IRQ_MASK, m_msk);
	endtask

	task span(input logic want, output int c);
		c = 0;
		do
		begin
			@(posedge clk_i);
			c++;
		end while (chip_reset_o !== want && c < 2000);
	endtask

	// start the watchdog with a kick, count edges until it resets the chip
	task automatic wdt_run(input logic [2:0] ps, input int kick_at, input int stall,
		output int c);
		int h;
		begin
			wr(rwd_pkg::ADDR_WCR, 8'h30 | ps);
			c = 0;
			do
			begin
				@(posedge clk_i);
				c++;
				cpu_idle_i <= (c >= 20 && c < 20 + stall);
				ce_i <= !(stall > 0 && c >= 20 + stall && c < 30 + stall);
				if (c == kick_at)
				begin
					wr(rwd_pkg::ADDR_WCR, 8'h30 | ps);
					c += 3;
				end
			end while (chip_reset_o !== 1'b1 && c < 20000);
			span(1'b0, h);
			chk_span(h, 22, 28);
			m_wcr = 8'h80;
			m_pcr = m_pcr & 8'h30;
			m_sts = m_sts | 1;
			rd(rwd_pkg::ADDR_WCR, m_wcr);
		end
	endtask

	initial
	begin
		repeat (40000) @(posedge clk_i);
		mismatches++;
		summarize();
	end

	initial
	begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		span(1'b0, n);
		chk_span(n, 62, 70);
		m_pcr = 8'h10;
		m_wcr = 8'h00;
		m_msk = 0;
		wr(rwd_pkg::ADDR_IRQ_STAT, 8'h0F);
		m_sts = 0;
		rd_all();
		rd(4'h2, 0);
		for (int i = 0; i < 4; i++)
		begin
			seed = lfsr_next(seed);
			cpu_idle_i <= seed[9];
			wr(rwd_pkg::ADDR_PCR, seed[7:0]);
			// run kept off: the fast watchdog would fire inside the loop
			wr(rwd_pkg::ADDR_WCR, seed[15:8] & 8'hDF);
			wr(4'h6, seed[23:16]);
			rd_all();
		end
		cpu_idle_i <= 1'b0;
		low_voltage_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		low_voltage_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		m_pcr = m_pcr | 8'h20;
		m_sts = m_sts | 2;
		rd_all();
		chk_bit(irq_o, 1'b0);
		wr(rwd_pkg::ADDR_IRQ_MASK, 8'h02);
		repeat (2) @(posedge clk_i);
		chk_bit(irq_o, 1'b1);
		wr(rwd_pkg::ADDR_IRQ_STAT, 8'h02);
		repeat (2) @(posedge clk_i);
		chk_bit(irq_o, 1'b0);
		wr(rwd_pkg::ADDR_PCR, 8'hC0);
		wr(rwd_pkg::ADDR_WCR, 8'h2B);
		rd_all();
		fork
			drv.pulse(200);
			begin
				span(1'b1, n);
				chk_span(n, 122, 134);
				span(1'b0, n);
				chk_span(n, 194, 206);
			end
		join
		m_pcr = m_pcr & 8'h30;
		m_wcr = m_wcr & 8'h80;
		m_sts = m_sts | 4;
		rd_all();
		supply_low_i <= 1'b1;
		span(1'b1, n);
		chk_span(n, 1, 5);
		repeat (10) @(posedge clk_i);
		supply_low_i <= 1'b0;
		span(1'b0, n);
		chk_span(n, 63, 72);
		m_pcr = m_pcr | 8'h10;
		m_sts = m_sts | 8;
		rd_all();
		wr(rwd_pkg::ADDR_PCR, 8'h00);
		soft_reset_req_i <= 1'b1;
		@(posedge clk_i);
		soft_reset_req_i <= 1'b0;
		span(1'b1, n);
		chk_span(n, 1, 2);
		span(1'b0, n);
		chk_span(n, 22, 28);
		rd_all();
		for (int ps = 0; ps < 8; ps++)
		begin
			wdt_run(ps[2:0], 0, 0, n);
			chk_span(n, (64 << ps) - 3, (64 << ps) + 3);
		end
		wdt_run(3'h0, 40, 0, n);
		chk_span(n, 104, 110);
		// 30 idle cycles then 10 with the clock enable low, both freeze the count
		wdt_run(3'h0, 0, 30, n);
		chk_span(n, 101, 107);
		rd_all();
		summarize();
	end
endmodule
